// file: rtl/ddc_nco_output_path.sv
// Receive output path: shared NCO, half-band decimator, FIR, fixed quarter-rate
// rotator, output coding, three-state control, interleaving and data clock.
// Assumes ADC samples arrive on clk as 14-bit twos complement; the serial
// control port runs on its own clock and is crossed by a toggle handshake.
// Functional notes
// (R01) Pin mode: format pin low gives offset binary, high gives twos complement.
// (R02) Serial control offers offset binary, twos complement and gray code.
// (R03) Output-disable pin high three-states data, low drives it; slow control.
// (R04) Output mode bit 4 three-states data and flags, per channel; here only data has an enable, or_a and or_b stay driven.
// (R05) Output mode bit 5 interleaves A and B on port A around clock edges.
// (R06) Registered outputs; latency depends on enabled stages; update after clock rise; here no stage setting changes the latency.
// (R07) A data clock output goes with the data for the receiver to capture.
// (R08) Codes map full scale per offset binary and twos complement tables.
// (R09) Chain holds NCO, half-band, FIR, coarse NCO; all but half-band switchable.
// (R10) Five recommended modes combine these stages for real or complex output.
// (R11) Half-band stage halves the sample rate while rejecting aliases.
// (R12) Optional FIR sharpens roll-off and removes negative-frequency images; here a two-tap average of I and Q alike, which removes no images.
// (R13) Coarse NCO shifts baseband from dc up to an eighth of sample rate.
// (R14) One NCO serves both channels, real in, complex I and Q out.
// (R15) NCO control bit 0 clear bypasses the NCO, set enables it.
// (R16) Tuning word is 32 bits from four byte registers, lowest first.
// (R17) Tuning word is twos complement spanning minus to plus half clock.
// (R18) Sync bits 3 and 4 restart NCO on every or first sync; phase starts at offset.
// (R19) Unsigned 16-bit phase offset adds to the accumulator phase.
// (R20) NCO control bit 1 enables amplitude dither in the sine lookup.
// (R21) Filter control bit 0 clear bypasses FIR; FIR needs the active half-band.
// (R22) Overrange flag marks clamped full-scale output codes.
// (R23) Coarse NCO has its own enable and passes data through when off.
`timescale 1ns/1ps
`include "ddc_defs.svh"

module ddc_nco_output_path (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] adc_a,
  input  wire logic [13:0] adc_b,
  input  wire logic        sync_pin,
  input  wire logic        format_select_pin,
  input  wire logic        output_disable_pin,
  input  wire logic        pin_mode,
  input  wire logic        ser_clk,
  input  wire logic        ser_sel_n,
  input  wire logic        ser_data,
  output logic      [13:0] data_a,
  output logic      [13:0] data_b,
  output logic             data_a_oe_n,
  output logic             data_b_oe_n,
  output logic             or_a,
  output logic             or_b,
  output logic             data_clock_out
);

  // Cosine lookup over eight phase steps, full scale 511.
  function automatic logic signed [9:0] cos8(input logic [2:0] i);
    logic signed [9:0] r;
    case (i)
      3'h0:    r = 10'sh1ff;
      3'h1:    r = 10'sh16a;
      3'h2:    r = 10'sh000;
      3'h3:    r = 10'sh296;
      3'h4:    r = 10'sh201;
      3'h5:    r = 10'sh296;
      3'h6:    r = 10'sh000;
      default: r = 10'sh16a;
    endcase
    return r;
  endfunction : cos8

  // Mixes a real sample with one lookup value and adds the dither bit.
  function automatic ddc_pkg::smp_t mix(input logic signed [13:0] x,
                                        input logic [2:0] i, input logic d);
    logic signed [23:0] p;
    p = x * cos8(i);
    return ddc_pkg::smp_t'(p >>> 9) + ddc_pkg::smp_t'({1'b0, d});
  endfunction : mix

  // Clamps to 14-bit twos complement; the top bit flags an overrange.
  function automatic logic [14:0] sat14(input ddc_pkg::smp_t v);
    logic [14:0] r;
    if (v > 18'sh01fff) r = {1'b1, 14'h1fff};
    else if (v < 18'sh3e000) r = {1'b1, 14'h2000};
    else r = {1'b0, v[13:0]};
    return r;
  endfunction : sat14

  // Recodes a twos complement sample into the selected output coding.
  function automatic logic [13:0] code14(input logic [13:0] t, input ddc_pkg::fmt_t f);
    logic [13:0] ob;
    logic [13:0] r;
    ob = {~t[13], t[12:0]};
    case (f)
      ddc_pkg::FMT_TWOS: r = t;
      ddc_pkg::FMT_GRAY: r = ob ^ (ob >> 1);
      default:           r = ob;
    endcase
    return r;
  endfunction : code14

  ddc_pkg::ser_t sp_ff;
  ddc_pkg::ser_t nxt_sp;
  logic [4:0]    cnt_ff;
  ddc_pkg::st_t  st_ff;
  ddc_pkg::st_t  nxt_st;
  logic          restart;
  logic [31:0]   acc_nxt;
  logic [17:0]   xa_ext;
  logic          cplx;
  logic          ilv;
  logic [15:0]   phs;
  ddc_pkg::fmt_t fa;
  ddc_pkg::fmt_t fb;

  // Bit counter of a serial frame; a deselect ends the frame at once.
  always_ff @(posedge ser_clk or posedge ser_sel_n) begin
    if (ser_sel_n) cnt_ff <= 5'h00;
    else if (cnt_ff != `SER_FRAME_BITS) cnt_ff <= cnt_ff + 5'h01;
  end

  // Shifts in a frame MSB first and publishes each completed write.
  always_comb begin
    nxt_sp = sp_ff;
    nxt_sp.shift = {sp_ff.shift[21:0], ser_data};
    if (cnt_ff == `SER_FRAME_BITS - 5'h01 && !sp_ff.shift[22]) begin
      nxt_sp.hold = {sp_ff.shift[19:7], sp_ff.shift[6:0], ser_data};
      nxt_sp.tog  = ~sp_ff.tog;
    end
  end

  // Serial side state; the write word stays still until the next frame ends.
  always_ff @(posedge ser_clk) begin
    if (!rst_n) sp_ff <= '0;
    else sp_ff <= nxt_sp;
  end

  // Restart on a rising sync edge as armed by the sync control register.
  assign restart = st_ff.syn[1] & ~st_ff.syn[2] & st_ff.sync_ctl[`BIT_SYNC_EN] &
                   (~st_ff.sync_ctl[`BIT_SYNC_ONCE] | st_ff.armed);  // R18
  assign acc_nxt = restart ? 32'h0000_0000 : st_ff.acc + st_ff.tw;  // R16 R17
  assign xa_ext  = {{4{adc_a[13]}}, adc_a};

  // Register writes, NCO, filters, rotator and output formatting.
  always_comb begin
    logic [2:0]       idx;
    logic             dith;
    logic signed [13:0] x;
    ddc_pkg::smp_t    hbi;
    ddc_pkg::smp_t    hbq;
    ddc_pkg::smp_t    ri;
    ddc_pkg::smp_t    rq;
    logic [1:0][14:0] si;
    logic [1:0][14:0] sq;
    idx  = 3'h0;
    dith = 1'b0;
    x    = 14'sh0000;
    hbi  = '0;
    hbq  = '0;
    ri   = '0;
    rq   = '0;
    si   = '0;
    sq   = '0;
    nxt_st = st_ff;
    // Two-flop synchronisers; a third stage feeds the edge detectors.
    nxt_st.syn   = {st_ff.syn[1:0], sync_pin};
    nxt_st.tog   = {st_ff.tog[1:0], sp_ff.tog};
    nxt_st.fmt_s = {st_ff.fmt_s[0], format_select_pin};
    nxt_st.dis_s = {st_ff.dis_s[0], output_disable_pin};
    nxt_st.pm_s  = {st_ff.pm_s[0], pin_mode};
    if (restart && st_ff.sync_ctl[`BIT_SYNC_ONCE]) nxt_st.armed = 1'b0;  // R18
    // Apply a write once its toggle has crossed.
    if (st_ff.tog[1] ^ st_ff.tog[2]) begin
      case (sp_ff.hold.addr)
        `OFS_CHSEL:  nxt_st.chsel = sp_ff.hold.data[1:0];
        `OFS_OMODE:  begin
          for (int c = 0; c < 2; c++) begin
            if (st_ff.chsel[c]) nxt_st.om[c] = sp_ff.hold.data;  // R02 R04
          end
        end
        `OFS_SYNC:   begin
          nxt_st.sync_ctl = sp_ff.hold.data;
          nxt_st.armed    = 1'b1;  // R18
        end
        `OFS_FILT:   nxt_st.filt_ctl = sp_ff.hold.data;  // R21
        `OFS_NCOCTL: nxt_st.nco_ctl = sp_ff.hold.data;  // R15 R20 R23
        `OFS_TW0:    nxt_st.tw[7:0] = sp_ff.hold.data;  // R16
        `OFS_TW1:    nxt_st.tw[15:8] = sp_ff.hold.data;
        `OFS_TW2:    nxt_st.tw[23:16] = sp_ff.hold.data;
        `OFS_TW3:    nxt_st.tw[31:24] = sp_ff.hold.data;
        `OFS_PH0:    nxt_st.poff[7:0] = sp_ff.hold.data;  // R19
        `OFS_PH1:    nxt_st.poff[15:8] = sp_ff.hold.data;
        default:     nxt_st.armed = nxt_st.armed;
      endcase
    end
    // Shared accumulator; the offset is added on the way to the lookup.
    nxt_st.acc  = acc_nxt;  // R14
    phs         = st_ff.acc[31:16] + st_ff.poff;  // R19
    idx         = phs[15:13];
    nxt_st.lfsr = {st_ff.lfsr[14:0],
                   st_ff.lfsr[15] ^ st_ff.lfsr[13] ^ st_ff.lfsr[12] ^ st_ff.lfsr[10]};
    dith        = st_ff.nco_ctl[`BIT_DITHER] & st_ff.lfsr[0];  // R20
    cplx = st_ff.nco_ctl[`BIT_NCO_EN] & ~st_ff.nco_ctl[`BIT_COARSE_EN];  // R10
    ilv  = st_ff.om[0][`BIT_OM_ILEAVE] & ~cplx;
    nxt_st.ph = ~st_ff.ph;
    for (int c = 0; c < 2; c++) begin
      x = (c == 0) ? adc_a : adc_b;
      // Mixer, or a straight pass of the real sample when bypassed.
      if (st_ff.nco_ctl[`BIT_NCO_EN]) begin
        nxt_st.mi[c] = mix(x, idx, dith);  // R14 R15
        nxt_st.mq[c] = -mix(x, 3'(idx - 3'h2), dith);
      end else begin
        nxt_st.mi[c] = {{4{x[13]}}, x};  // R15
        nxt_st.mq[c] = '0;
      end
      nxt_st.hi1[c] = st_ff.mi[c];
      nxt_st.hi2[c] = st_ff.hi1[c];
      nxt_st.hq1[c] = st_ff.mq[c];
      nxt_st.hq2[c] = st_ff.hq1[c];
      // Half-band: binomial low-pass, one output every second sample.
      hbi = (st_ff.mi[c] + (st_ff.hi1[c] <<< 1) + st_ff.hi2[c]) >>> 2;  // R11
      hbq = (st_ff.mq[c] + (st_ff.hq1[c] <<< 1) + st_ff.hq2[c]) >>> 2;
      ri  = hbi;
      rq  = hbq;
      if (st_ff.ph) begin
        nxt_st.fi[c] = hbi;
        nxt_st.fq[c] = hbq;
        // FIR averages adjacent decimated outputs; only after the half-band.
        if (st_ff.filt_ctl[`BIT_FIR_EN]) begin
          ri = (hbi + st_ff.fi[c]) >>> 1;  // R12 R21
          rq = (hbq + st_ff.fq[c]) >>> 1;
        end
        // Quarter turn per output sample shifts the band to an eighth of the rate.
        if (st_ff.nco_ctl[`BIT_COARSE_EN]) begin
          case (st_ff.q4)
            2'h0:    ri = ri;  // R13
            2'h1:    ri = -rq;
            2'h2:    ri = -ri;
            default: ri = rq;
          endcase
        end  // R23
      end
      si[c] = sat14(ri);  // R22
      sq[c] = sat14(rq);
    end
    if (st_ff.ph && st_ff.nco_ctl[`BIT_COARSE_EN]) nxt_st.q4 = st_ff.q4 + 2'h1;  // R09
    // Coding per channel: the pin picks it in pin mode, the register otherwise.
    if (st_ff.pm_s[1]) begin
      fa = st_ff.fmt_s[1] ? ddc_pkg::FMT_TWOS : ddc_pkg::FMT_OFFSET;  // R01
      fb = fa;
    end else begin
      fa = ddc_pkg::fmt_t'(st_ff.om[0][1:0]);  // R02
      fb = ddc_pkg::fmt_t'(st_ff.om[1][1:0]);
    end
    // Output stage: first slot on the data clock high, second on it low.
    if (st_ff.ph) begin
      nxt_st.dclk = 1'b1;  // R07
      nxt_st.pa   = code14(si[0][13:0], fa);  // R08
      nxt_st.ora  = si[0][14];  // R22
      nxt_st.oq   = sq;
      if (ilv) begin
        nxt_st.hold_b = si[1];  // R05
      end else begin
        nxt_st.pb  = code14(si[1][13:0], fb);
        nxt_st.orb = si[1][14];
      end
    end else begin
      nxt_st.dclk = 1'b0;  // R06
      if (ilv) begin
        nxt_st.pa  = code14(st_ff.hold_b[13:0], fa);  // R05
        nxt_st.ora = st_ff.hold_b[14];
      end else if (cplx) begin
        nxt_st.pa  = code14(st_ff.oq[0][13:0], fa);  // R10
        nxt_st.ora = st_ff.oq[0][14];
        nxt_st.pb  = code14(st_ff.oq[1][13:0], fb);
        nxt_st.orb = st_ff.oq[1][14];
      end
    end
    // Three-state control from the pin in pin mode, per channel otherwise.
    nxt_st.oe_a_n = st_ff.pm_s[1] ? st_ff.dis_s[1] : st_ff.om[0][`BIT_OM_DISABLE];  // R03 R04
    nxt_st.oe_b_n = st_ff.pm_s[1] ? st_ff.dis_s[1] : st_ff.om[1][`BIT_OM_DISABLE];
  end

  // Reset value of the core state: outputs disabled, both channels selected.
  function automatic ddc_pkg::st_t st_reset();
    ddc_pkg::st_t r;
    r          = '0;
    r.om       = {`RST_OMODE, `RST_OMODE};
    r.chsel    = `RST_CHSEL;
    r.nco_ctl  = `RST_CTL;
    r.filt_ctl = `RST_CTL;
    r.sync_ctl = `RST_CTL;
    r.lfsr     = `LFSR_SEED;
    r.oe_a_n   = 1'b1;
    r.oe_b_n   = 1'b1;
    return r;
  endfunction : st_reset

  // Core state register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) st_ff <= st_reset();
    else st_ff <= nxt_st;
  end

  // Outputs straight from the state register.
  assign data_a         = st_ff.pa;
  assign data_b         = st_ff.pb;
  assign or_a           = st_ff.ora;
  assign or_b           = st_ff.orb;
  assign data_a_oe_n    = st_ff.oe_a_n;
  assign data_b_oe_n    = st_ff.oe_b_n;
  assign data_clock_out = st_ff.dclk;

  // A disable from the pin reaches port A within three clocks.
  property p_pin_dis;
    @(posedge clk) disable iff (!rst_n)
      (st_ff.pm_s[1] && $rose(st_ff.dis_s[1])) |=> data_a_oe_n;
  endproperty
  a_pin_dis: assert property (p_pin_dis) else $error("pin disable not applied");  // R03

  // The register disable bit of channel B three-states port B.
  property p_reg_dis;
    @(posedge clk) disable iff (!rst_n)
      (!st_ff.pm_s[1] && st_ff.om[1][`BIT_OM_DISABLE]) |=> data_b_oe_n;
  endproperty
  a_reg_dis: assert property (p_reg_dis) else $error("register disable ignored");  // R04

  // Data clock runs at half the sample clock.
  property p_dclk;
    @(posedge clk) disable iff (!rst_n)
      $rose(data_clock_out) |=> !data_clock_out ##1 data_clock_out;
  endproperty
  a_dclk: assert property (p_dclk) else $error("data clock not at half rate");  // R07 R11

  // In interleaved real mode port A carries the channel B sample while the data clock is low.
  property p_ilv;
    @(posedge clk) disable iff (!rst_n)
      (st_ff.om[0][`BIT_OM_ILEAVE] && !st_ff.nco_ctl[`BIT_NCO_EN] && !data_clock_out)
      |-> data_a == code14(st_ff.hold_b[13:0], ddc_pkg::fmt_t'(st_ff.om[0][1:0]))
          || st_ff.pm_s[1] || $changed(st_ff.om) || $changed(st_ff.nco_ctl);
  endproperty
  a_ilv: assert property (p_ilv) else $error("channel B missing on port A");  // R05

  // A bypassed NCO passes the real sample unchanged.
  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
      !st_ff.nco_ctl[`BIT_NCO_EN] |=> st_ff.mi[0] == $past(xa_ext) || $changed(st_ff.nco_ctl);
  endproperty
  a_bypass: assert property (p_bypass) else $error("NCO bypass altered data");  // R15

  // The accumulator advances by the tuning word unless restarted.
  property p_acc;
    @(posedge clk) disable iff (!rst_n)
      !restart |=> st_ff.acc == $past(st_ff.acc) + $past(st_ff.tw);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator step wrong");  // R16

  // A sync restart clears the accumulator and disarms one-shot mode.
  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      (restart && st_ff.sync_ctl[`BIT_SYNC_ONCE] && !(st_ff.tog[1] ^ st_ff.tog[2]))
      |=> st_ff.acc == 32'h0000_0000 && !st_ff.armed;
  endproperty
  a_restart: assert property (p_restart) else $error("sync restart failed");  // R18

  // A flagged overrange carries a full-scale code.
  property p_ovr;
    @(posedge clk) disable iff (!rst_n)
      or_a |-> data_a == 14'h3fff || data_a == 14'h0000 || data_a == 14'h1fff
               || data_a == 14'h2000;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrange code not full scale");  // R22

endmodule : ddc_nco_output_path

// file: rtl/ddc_defs.svh
// Register offsets, field positions and reset values of the receive output path.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH

// Register offsets on the serial control port (13-bit addresses).
`define OFS_CHSEL       13'h005
`define OFS_OMODE       13'h014
`define OFS_SYNC        13'h100
`define OFS_FILT        13'h102
`define OFS_NCOCTL      13'h11d
`define OFS_TW0         13'h11e
`define OFS_TW1         13'h11f
`define OFS_TW2         13'h120
`define OFS_TW3         13'h121
`define OFS_PH0         13'h122
`define OFS_PH1         13'h123

// Field positions.
`define BIT_FMT_LO      0
`define BIT_OM_DISABLE  4
`define BIT_OM_ILEAVE   5
`define BIT_NCO_EN      0
`define BIT_DITHER      1
`define BIT_COARSE_EN   3
`define BIT_SYNC_EN     3
`define BIT_SYNC_ONCE   4
`define BIT_FIR_EN      0

// Reset values.
`define RST_OMODE       8'h00
`define RST_CHSEL       2'h3
`define RST_CTL         8'h00
`define LFSR_SEED       16'hace1

// Serial frame: one instruction of 16 bits and one data byte.
`define SER_FRAME_BITS  5'h18

`endif

// file: rtl/ddc_pkg.sv
// Types shared by the receive output path.
// Assumes the constants of ddc_defs.svh for offsets and field positions.
package ddc_pkg;

  // Internal sample word, wide enough for mixer and filter growth.
  typedef logic signed [17:0] smp_t;

  // Output sample codings selected by the two low bits of the output mode register.
  typedef enum logic [1:0] {
    FMT_OFFSET = 2'b00,
    FMT_TWOS   = 2'b01,
    FMT_GRAY   = 2'b10
  } fmt_t;

  // One register write carried from the serial clock domain.
  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  data;
  } wr_t;

  // Serial side state.
  typedef struct packed {
    logic [22:0] shift;
    wr_t         hold;
    logic        tog;
  } ser_t;

  // Core state on the sample clock.
  typedef struct packed {
    logic [1:0][7:0]  om;
    logic [1:0]       chsel;
    logic [7:0]       nco_ctl;
    logic [7:0]       filt_ctl;
    logic [7:0]       sync_ctl;
    logic [31:0]      tw;
    logic [15:0]      poff;
    logic [2:0]       syn;
    logic [2:0]       tog;
    logic [1:0]       fmt_s;
    logic [1:0]       dis_s;
    logic [1:0]       pm_s;
    logic             armed;
    logic [31:0]      acc;
    logic [15:0]      lfsr;
    logic             ph;
    logic [1:0]       q4;
    smp_t [1:0]       mi;
    smp_t [1:0]       mq;
    smp_t [1:0]       hi1;
    smp_t [1:0]       hi2;
    smp_t [1:0]       hq1;
    smp_t [1:0]       hq2;
    smp_t [1:0]       fi;
    smp_t [1:0]       fq;
    logic [1:0][14:0] oq;
    logic [14:0]      hold_b;
    logic [13:0]      pa;
    logic [13:0]      pb;
    logic             ora;
    logic             orb;
    logic             oe_a_n;
    logic             oe_b_n;
    logic             dclk;
  } st_t;

endpackage : ddc_pkg

// file: verif/capture_model.sv
// Model of the downstream capture logic that latches the output stream.
// Assumes it shares the sample clock and qualifies the two slots of a pair
// with the level of the data clock output.
`timescale 1ns/1ps

module capture_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        data_clock_out,
  input  wire logic [13:0] data_a,
  input  wire logic [13:0] data_b,
  input  wire logic        data_a_oe_n,
  input  wire logic        data_b_oe_n,
  output logic      [13:0] hi_a_ff,
  output logic      [13:0] lo_a_ff,
  output logic      [13:0] hi_b_ff,
  output logic      [31:0] bad_ff
);
  logic [13:0] bus_a;
  logic [13:0] bus_b;
  logic        last_ff;
  logic        seen_ff;

  // A released bus shows a changing pattern, never the last driven value.
  assign bus_a = data_a_oe_n ? ~hi_a_ff : data_a;
  assign bus_b = data_b_oe_n ? ~hi_b_ff : data_b;

  // Slots are taken by the data clock level; it must alternate every cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_a_ff <= 14'h0000;
      lo_a_ff <= 14'h0000;
      hi_b_ff <= 14'h0000;
      bad_ff  <= 32'h0;
      last_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      last_ff <= data_clock_out;
      seen_ff <= seen_ff | data_clock_out;
      if (data_clock_out) begin
        hi_a_ff <= bus_a;
        hi_b_ff <= bus_b;
      end else begin
        lo_a_ff <= bus_a;
      end
      if (seen_ff && data_clock_out === last_ff) begin
        bad_ff <= bad_ff + 32'h1;
      end
    end
  end
endmodule : capture_model

// file: verif/tb.sv
// Self-checking bench for the receive output path.
// Assumes the serial port is write-only, so results are seen at the outputs.
`timescale 1ns/1ps
`include "ddc_defs.svh"

module tb;
  logic        clk;
  logic        rst_n;
  logic [13:0] adc_a;
  logic [13:0] adc_b;
  logic        sync_pin;
  logic        format_select_pin;
  logic        output_disable_pin;
  logic        pin_mode;
  logic        ser_clk;
  logic        ser_sel_n;
  logic        ser_data;
  logic [13:0] data_a;
  logic [13:0] data_b;
  logic        data_a_oe_n;
  logic        data_b_oe_n;
  logic        or_a;
  logic        or_b;
  logic        data_clock_out;
  logic [13:0] hi_a;
  logic [13:0] lo_a;
  logic [13:0] hi_b;
  logic [31:0] bad;
  logic [13:0] vals [3];
  int          n_mismatch;
  int          checks;
  int          n_or;

  // Sample clock of 20 ns.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ddc_nco_output_path dut (
    .clk(clk), .rst_n(rst_n), .adc_a(adc_a), .adc_b(adc_b), .sync_pin(sync_pin),
    .format_select_pin(format_select_pin), .output_disable_pin(output_disable_pin),
    .pin_mode(pin_mode), .ser_clk(ser_clk), .ser_sel_n(ser_sel_n), .ser_data(ser_data),
    .data_a(data_a), .data_b(data_b), .data_a_oe_n(data_a_oe_n),
    .data_b_oe_n(data_b_oe_n), .or_a(or_a), .or_b(or_b),
    .data_clock_out(data_clock_out));

  capture_model cap (
    .clk(clk), .rst_n(rst_n), .data_clock_out(data_clock_out), .data_a(data_a),
    .data_b(data_b), .data_a_oe_n(data_a_oe_n), .data_b_oe_n(data_b_oe_n),
    .hi_a_ff(hi_a), .lo_a_ff(lo_a), .hi_b_ff(hi_b), .bad_ff(bad));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Exact comparison of a value seen at the outputs.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Comparison within a tolerance, for mixer products that carry rounding.
  task automatic chk_near(input logic [13:0] got, input int exp, input int tol,
                          input string what);
    int diff;
    checks++;
    diff = int'($signed(got)) - exp;
    if ((^got === 1'bx) || diff > tol || diff < -tol) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h near %0d", $time, what, got, exp);
    end
  endtask : chk_near

  // One write frame, clocked by a 6 ns serial clock that runs only in the frame.
  task automatic ser_write(input logic [12:0] addr, input logic [7:0] data);
    logic [23:0] frame;
    frame = {1'b0, 2'b00, addr, data};
    @(posedge clk);
    ser_sel_n <= 1'b0;
    #7;
    for (int i = 23; i >= 0; i--) begin
      ser_data = frame[i];
      #3 ser_clk = 1'b1;
      #3 ser_clk = 1'b0;
    end
    @(posedge clk);
    ser_sel_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : ser_write

  // Lets the filters fill with a constant input before the slots are read.
  task automatic settle();
    repeat (40) @(posedge clk);
    #1;
  endtask : settle

  // Expected output code of a twos complement sample under each coding.
  function automatic logic [13:0] code(input logic [13:0] x, input logic [1:0] f);
    logic [13:0] ob;
    ob = x ^ 14'h2000;
    case (f)
      2'b01: code = x;
      2'b10: code = ob ^ (ob >> 1);
      default: code = ob;
    endcase
  endfunction : code

  // Watchdog sized at several times the roughly 1500 cycles the tests need.
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    adc_a = 14'h0000;
    adc_b = 14'h0000;
    sync_pin = 1'b0;
    format_select_pin = 1'b0;
    output_disable_pin = 1'b0;
    pin_mode = 1'b1;
    ser_clk = 1'b0;
    ser_sel_n = 1'b1;
    ser_data = 1'b0;
    n_mismatch = 0;
    checks = 0;
    vals = '{14'h2000, 14'h0000, 14'h1fff};
    // The serial side resets on its own clock, so it gets edges in reset.
    repeat (2) begin
      #3 ser_clk = 1'b1;
      #3 ser_clk = 1'b0;
    end
    repeat (8) @(posedge clk);
    #1;
    chk(data_a, 14'h0000, "reset data");
    chk(data_a_oe_n, 1'b1, "reset oe");
    chk(data_clock_out, 1'b0, "reset dclk");
    @(posedge clk);
    rst_n <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      for (int v = 0; v < 3; v++) begin
        @(posedge clk);
        format_select_pin <= f[0];
        adc_a <= vals[v];
        adc_b <= vals[v];
        settle();
        chk(hi_a, code(vals[v], f[1:0]), "pin coding a");
        chk(hi_b, code(vals[v], f[1:0]), "pin coding b");
        chk(or_a, 1'b0, "in range flag");
        chk(or_b, 1'b0, "in range flag b");
      end
    end
    @(posedge clk);
    output_disable_pin <= 1'b1;
    settle();
    chk({data_a_oe_n, data_b_oe_n}, 2'b11, "pin disable");
    @(posedge clk);
    output_disable_pin <= 1'b0;
    pin_mode <= 1'b0;
    settle();
    chk({data_a_oe_n, data_b_oe_n}, 2'b00, "pin enable");
    for (int f = 0; f < 3; f++) begin
      ser_write(`OFS_OMODE, {6'h00, f[1:0]});
      for (int v = 0; v < 3; v++) begin
        @(posedge clk);
        adc_a <= vals[v];
        settle();
        chk(hi_a, code(vals[v], f[1:0]), "serial coding");
      end
    end
    ser_write(`OFS_OMODE, 8'h21);
    @(posedge clk);
    adc_a <= 14'h03e8;
    adc_b <= 14'h3c18;
    settle();
    chk(hi_a, 14'h03e8, "interleave high slot");
    chk(lo_a, 14'h3c18, "interleave low slot");
    ser_write(`OFS_CHSEL, 8'h01);
    ser_write(`OFS_OMODE, 8'h11);
    settle();
    chk({data_a_oe_n, data_b_oe_n}, 2'b10, "disable a only");
    ser_write(`OFS_CHSEL, 8'h02);
    ser_write(`OFS_OMODE, 8'h11);
    settle();
    chk({data_a_oe_n, data_b_oe_n}, 2'b11, "disable b too");
    ser_write(`OFS_CHSEL, 8'h03);
    ser_write(`OFS_OMODE, 8'h01);
    settle();
    chk({data_a_oe_n, data_b_oe_n}, 2'b00, "enable both");
    @(posedge clk);
    adc_a <= 14'h0fa0;
    ser_write(`OFS_NCOCTL, 8'h03);
    settle();
    chk_near(hi_a, 4000, 500, "nco in phase");
    chk_near(lo_a, 0, 64, "nco quadrature");
    ser_write(`OFS_PH1, 8'h40);
    settle();
    chk_near(hi_a, 0, 64, "quarter turn offset");
    ser_write(`OFS_TW3, 8'h80);
    settle();
    chk_near(lo_a, 0, 64, "half clock tuning");
    ser_write(`OFS_SYNC, 8'h18);
    @(posedge clk);
    sync_pin <= 1'b1;
    settle();
    ser_write(`OFS_NCOCTL, 8'h00);
    settle();
    chk(hi_a, 14'h0fa0, "nco bypass");
    ser_write(`OFS_FILT, 8'h01);
    settle();
    chk(hi_a, 14'h0fa0, "fir passes dc");
    @(posedge clk);
    adc_a <= 14'h2000;
    ser_write(`OFS_NCOCTL, 8'h08);
    settle();
    n_or = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      n_or += or_a;
    end
    chk(n_or, 32'h2, "coarse rotation overrange");
    chk(bad, 32'h0, "data clock alternation");
    stop_test();
  end
endmodule : tb
